// ==== spm_consts.svh ====
// Constants for the switch port mirroring block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
`define SPM_CLK_NS        5
`define SPM_RATE_MIN_GBPS 6'h01
`define SPM_RATE_MAX_GBPS 6'h28
`define SPM_MTU_DEFAULT   14'h09C4
`define SPM_MTU_JUMBO     14'h2400
`define SPM_SESS_CLUSTER  512
`define SPM_SESS_BOX      48
`define SPM_SESS_PER_GRP  8
`define SPM_PORTS_PER_GRP 8
`define SPM_SESS_SMALL    7
`define SPM_SESS_SHARED   24
`endif

// ==== spm_pkg.sv ====
// Types of the switch port mirroring block.
// Assumes spm_consts.svh is compiled alongside.
package spm_pkg;
   typedef enum logic [1:0] {
      SPM_DIR_OFF  = 2'b00,
      SPM_DIR_RX   = 2'b01,
      SPM_DIR_TX   = 2'b10,
      SPM_DIR_BOTH = 2'b11
   } spm_dir_t;
   typedef enum logic [3:0] {
      SPM_ERR_NONE       = 4'b0000,
      SPM_ERR_LAG        = 4'b0001,
      SPM_ERR_TRILL_DST  = 4'b0010,
      SPM_ERR_ISL_REMOTE = 4'b0011,
      SPM_ERR_TRILL_BOTH = 4'b0100,
      SPM_ERR_RVLAN      = 4'b0101,
      SPM_ERR_BIDIR      = 4'b0110,
      SPM_ERR_MTU        = 4'b0111,
      SPM_ERR_GROUP      = 4'b1000
   } spm_err_t;
endpackage

// ==== spm_rate.sv ====
// Token bucket limiting mirrored bits to the destination line rate.
// Assumes take is raised only while ok is high.
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_rate #(
   parameter int unsigned BURST_BITS = 131072,
   parameter int unsigned TW         = 24
) (
   input  wire logic          clk_sys,
   input  wire logic          srst,
   input  wire logic [5:0]    rate_gbps,
   input  wire logic [13:0]   len_bytes,
   input  wire logic          take,
   output logic               ok
);
   localparam logic [TW-1:0] BURST = TW'(BURST_BITS);
   logic [TW-1:0] tok_q;
   logic [TW-1:0] tok_d;
   logic [5:0]    rate;
   logic [TW-1:0] add;
   logic [TW-1:0] cost;
   logic [TW:0]   sum;

   always_comb begin
      rate = rate_gbps;
      // Out-of-range settings clamp to the supported line rates
      if (rate < `SPM_RATE_MIN_GBPS) rate = `SPM_RATE_MIN_GBPS;
      if (rate > `SPM_RATE_MAX_GBPS) rate = `SPM_RATE_MAX_GBPS;
      // One Gbps over one period of n ns is n bits
      add  = TW'(rate) * TW'(`SPM_CLK_NS);
      cost = TW'({len_bytes, 3'b000});
      ok   = (tok_q >= cost);
      sum  = {1'b0, tok_q} + {1'b0, add} - (take ? {1'b0, cost} : '0);
      // Bucket depth bounds the burst that can be copied at once
      tok_d = (sum > {1'b0, BURST}) ? BURST : sum[TW-1:0];
   end

   always_ff @(posedge clk_sys) begin
      if (srst) tok_q <= '0;
      else      tok_q <= tok_d;
   end
endmodule

// ==== spm_rvlan.sv ====
// Table of VLANs designated for remote mirroring, with two lookups.
// Assumes one designation request per cycle at most.
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_rvlan #(
   parameter int unsigned NRV = 4
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        rv_req,
   input  wire logic        rv_add,
   input  wire logic [11:0] rv_vlan,
   input  wire logic        rv_native,
   input  wire logic        rv_members,
   output logic             rv_ack_q,
   output logic             rv_ok_q,
   input  wire logic [11:0] lk_a_vlan,
   output logic             lk_a_hit,
   input  wire logic [11:0] lk_b_vlan,
   output logic             lk_b_hit
);
   logic [11:0]    v_q [NRV];
   logic [NRV-1:0] vv_q;
   logic [NRV-1:0] m_req;
   logic [NRV-1:0] m_a;
   logic [NRV-1:0] m_b;
   logic           full;
   logic           refuse;
   int             fr;

   for (genvar k = 0; k < NRV; k++) begin : g_cmp
      assign m_req[k] = vv_q[k] && (v_q[k] == rv_vlan);
      assign m_a[k]   = vv_q[k] && (v_q[k] == lk_a_vlan);
      assign m_b[k]   = vv_q[k] && (v_q[k] == lk_b_vlan);
   end

   assign lk_a_hit = |m_a;
   assign lk_b_hit = |m_b;
   assign full     = &vv_q;
   // A VLAN in live use would mix user traffic into the copies
   assign refuse   = rv_native || rv_members || (full && !(|m_req));

   always_comb begin
      fr = 0;
      for (int k = NRV - 1; k >= 0; k--) begin
         if (!vv_q[k]) fr = k;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         vv_q <= '0;
         for (int k = 0; k < NRV; k++) v_q[k] <= 12'h000;
      end else if (rv_req) begin
         if (!rv_add) vv_q <= vv_q & ~m_req;
         else if (!refuse && !(|m_req)) begin
            vv_q[fr] <= 1'b1;
            v_q[fr]  <= rv_vlan;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rv_ack_q <= 1'b0;
         rv_ok_q  <= 1'b0;
      end else begin
         rv_ack_q <= rv_req;
         rv_ok_q  <= rv_req && (!rv_add || !refuse);
      end
   end
endmodule

// ==== spm_mirror.sv ====
// Port mirroring core: session table, admission checks, copy path.
// Assumes one packet descriptor per cycle, synchronous to clk_sys.
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_mirror #(
   parameter int unsigned NPORT      = 64,
   parameter int unsigned PW         = 6,
   parameter int unsigned NSESS      = `SPM_SESS_BOX,
   parameter int unsigned NRV        = 4,
   parameter int unsigned CHIP_PORTS = 16,
   parameter int unsigned BURST_BITS = 131072,
   localparam int unsigned IW        = $clog2(NSESS),
   localparam int unsigned CW        = $clog2(NSESS + 1)
) (
   input  wire logic               clk_sys,
   input  wire logic               srst,
   input  wire logic               cfg_we,
   input  wire logic [IW-1:0]      cfg_idx,
   input  wire logic               cfg_en,
   input  wire logic [PW-1:0]      cfg_src,
   input  wire spm_pkg::spm_dir_t  cfg_dir,
   input  wire logic [PW-1:0]      cfg_dst,
   input  wire logic               cfg_remote,
   input  wire logic [11:0]        cfg_rvlan,
   output logic                    cfg_ack_q,
   output spm_pkg::spm_err_t       cfg_err_q,
   input  wire logic               rv_req,
   input  wire logic               rv_add,
   input  wire logic [11:0]        rv_vlan,
   input  wire logic               rv_native,
   input  wire logic               rv_members,
   output logic                    rv_ack_q,
   output logic                    rv_ok_q,
   input  wire logic [NPORT-1:0]   port_lag,
   input  wire logic [NPORT-1:0]   port_trill,
   input  wire logic [NPORT-1:0]   port_isl,
   input  wire logic [NPORT-1:0]   port_l2,
   input  wire logic [NPORT-1:0]   port_l3,
   input  wire logic [NPORT-1:0]   port_mtu_dflt,
   input  wire logic [5:0]         dst_rate_gbps,
   input  wire logic               pkt_valid,
   input  wire logic [15:0]        pkt_id,
   input  wire logic [PW-1:0]      pkt_port,
   input  wire logic               pkt_dir,
   input  wire logic               pkt_tagged,
   input  wire logic [11:0]        pkt_vlan,
   input  wire logic [13:0]        pkt_len,
   input  wire logic               pkt_pause,
   input  wire logic               pkt_mcast,
   input  wire logic               pkt_bcast,
   input  wire logic               pkt_learn,
   output logic                    fwd_valid_q,
   output logic [15:0]             fwd_id_q,
   output logic                    learn_valid_q,
   output logic [15:0]             learn_id_q,
   output logic                    mir_valid_q,
   input  wire logic               mir_ready,
   output logic [15:0]             mir_id_q,
   output logic [PW-1:0]           mir_port_q,
   output logic [11:0]             mir_vlan_q,
   output logic                    mir_tagged_q,
   output logic                    mir_remote_q,
   output logic [13:0]             mir_len_q,
   output logic                    mir_drop_q,
   output logic                    stat_tx_mc_q,
   output logic                    stat_tx_bc_q,
   output logic                    cnt_clr_q,
   output logic [PW-1:0]           cnt_clr_port_q,
   output logic [NPORT*14-1:0]     port_mtu_q
);
   // Session table
   logic                 s_en_q  [NSESS];
   logic [PW-1:0]        s_src_q [NSESS];
   spm_pkg::spm_dir_t    s_dir_q [NSESS];
   logic [PW-1:0]        s_dst_q [NSESS];
   logic                 s_rem_q [NSESS];
   logic [11:0]          s_rv_q  [NSESS];

   logic                 hit_any;
   logic [IW-1:0]        sel;
   logic                 unk_untag;
   logic                 rem_untag;
   logic                 cand;
   logic                 stall;
   logic                 rate_ok;
   logic                 copy_go;
   logic                 rv_hit_pkt;
   logic                 rv_hit_cfg;
   logic [NPORT-1:0]     dst_used;
   logic                 bidir_hit;
   logic [CW-1:0]        grp_cnt;
   spm_pkg::spm_err_t    err;
   logic                 cfg_acc;
   logic                 mir_mc_q;
   logic                 mir_bc_q;

   spm_rvlan #(
      .NRV        (NRV)
   ) u_rvlan (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .rv_req     (rv_req),
      .rv_add     (rv_add),
      .rv_vlan    (rv_vlan),
      .rv_native  (rv_native),
      .rv_members (rv_members),
      .rv_ack_q   (rv_ack_q),
      .rv_ok_q    (rv_ok_q),
      .lk_a_vlan  (pkt_vlan),
      .lk_a_hit   (rv_hit_pkt),
      .lk_b_vlan  (cfg_rvlan),
      .lk_b_hit   (rv_hit_cfg)
   );

   spm_rate #(
      .BURST_BITS (BURST_BITS)
   ) u_rate (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .rate_gbps  (dst_rate_gbps),
      .len_bytes  (pkt_len),
      .take       (copy_go),
      .ok         (rate_ok)
   );

   // Lowest matching session wins; one copy per packet
   always_comb begin
      hit_any = 1'b0;
      sel     = '0;
      for (int i = NSESS - 1; i >= 0; i--) begin
         if (s_en_q[i] && s_src_q[i] == pkt_port &&
             (pkt_dir ? s_dir_q[i][1] : s_dir_q[i][0])) begin
            hit_any = 1'b1;
            sel     = IW'(i);
         end
      end
   end

   assign unk_untag = !pkt_tagged && !port_l2[pkt_port] &&
                      !port_l3[pkt_port];
   // Inter-switch trunks discard untagged frames from non layer 2 sources anyway
   assign rem_untag = s_rem_q[sel] && !pkt_tagged &&
                      !port_l2[pkt_port];
   assign cand      = pkt_valid && hit_any && !pkt_pause &&
                      !unk_untag && !rem_untag;
   // No queue here: a held output means the copy is lost
   assign stall     = mir_valid_q && !mir_ready;
   assign copy_go   = cand && !stall && rate_ok;

   // Original path: fixed one-cycle delay, independent of mirroring
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fwd_valid_q <= 1'b0;
         fwd_id_q    <= 16'h0000;
      end else begin
         fwd_valid_q <= pkt_valid && !unk_untag;
         fwd_id_q    <= pkt_id;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         learn_valid_q <= 1'b0;
         learn_id_q    <= 16'h0000;
      end else begin
         learn_valid_q <= pkt_valid && pkt_learn && !unk_untag &&
                          !rv_hit_pkt;
         learn_id_q    <= pkt_id;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mir_valid_q  <= 1'b0;
         mir_id_q     <= 16'h0000;
         mir_port_q   <= '0;
         mir_vlan_q   <= 12'h000;
         mir_tagged_q <= 1'b0;
         mir_remote_q <= 1'b0;
         mir_len_q    <= 14'h0000;
         mir_mc_q     <= 1'b0;
         mir_bc_q     <= 1'b0;
      end else if (copy_go) begin
         mir_valid_q  <= 1'b1;
         mir_id_q     <= pkt_id;
         mir_port_q   <= s_dst_q[sel];
         mir_vlan_q   <= s_rem_q[sel] ? s_rv_q[sel] : pkt_vlan;
         mir_tagged_q <= s_rem_q[sel] || pkt_tagged;
         mir_remote_q <= s_rem_q[sel];
         mir_len_q    <= pkt_len;
         mir_mc_q     <= pkt_mcast;
         mir_bc_q     <= pkt_bcast;
      end else if (mir_ready) begin
         mir_valid_q  <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mir_drop_q   <= 1'b0;
         stat_tx_mc_q <= 1'b0;
         stat_tx_bc_q <= 1'b0;
      end else begin
         mir_drop_q   <= cand && !copy_go;
         stat_tx_mc_q <= mir_valid_q && mir_ready && mir_mc_q;
         stat_tx_bc_q <= mir_valid_q && mir_ready && mir_bc_q;
      end
   end

   // Admission scan; destination use covers every session, bidir and group checks only the other sessions
   always_comb begin
      dst_used  = '0;
      bidir_hit = 1'b0;
      grp_cnt   = '0;
      for (int j = 0; j < NSESS; j++) begin
         if (s_en_q[j]) dst_used[s_dst_q[j]] = 1'b1;
         if (s_en_q[j] && IW'(j) != cfg_idx) begin
            if ((s_dst_q[j] / PW'(CHIP_PORTS)) ==
                (cfg_dst / PW'(CHIP_PORTS)) && s_dst_q[j] != cfg_dst &&
                (s_dir_q[j] == spm_pkg::SPM_DIR_BOTH ||
                 cfg_dir == spm_pkg::SPM_DIR_BOTH))
               bidir_hit = 1'b1;
            if ((s_dst_q[j] / PW'(`SPM_PORTS_PER_GRP)) ==
                (cfg_dst / PW'(`SPM_PORTS_PER_GRP)))
               grp_cnt = grp_cnt + CW'(1);
         end
      end
   end

   always_comb begin
      err = spm_pkg::SPM_ERR_NONE;
      if (!cfg_en)
         err = spm_pkg::SPM_ERR_NONE;
      else if (port_lag[cfg_src])
         err = spm_pkg::SPM_ERR_LAG;
      else if (cfg_remote && port_isl[cfg_src])
         err = spm_pkg::SPM_ERR_ISL_REMOTE;
      else if (cfg_remote && port_trill[cfg_src] && port_trill[cfg_dst])
         err = spm_pkg::SPM_ERR_TRILL_BOTH;
      else if (port_trill[cfg_dst])
         err = spm_pkg::SPM_ERR_TRILL_DST;
      else if (cfg_remote && !rv_hit_cfg)
         err = spm_pkg::SPM_ERR_RVLAN;
      else if (bidir_hit)
         err = spm_pkg::SPM_ERR_BIDIR;
      else if (!dst_used[cfg_dst] && !port_mtu_dflt[cfg_dst])
         err = spm_pkg::SPM_ERR_MTU;
      else if (grp_cnt >= CW'(`SPM_SESS_PER_GRP))
         err = spm_pkg::SPM_ERR_GROUP;
   end

   assign cfg_acc = cfg_we && err == spm_pkg::SPM_ERR_NONE;

   // Table size bounds the session count of this device
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < NSESS; i++) begin
            s_en_q[i]  <= 1'b0;
            s_src_q[i] <= '0;
            s_dir_q[i] <= spm_pkg::SPM_DIR_OFF;
            s_dst_q[i] <= '0;
            s_rem_q[i] <= 1'b0;
            s_rv_q[i]  <= 12'h000;
         end
      end else if (cfg_acc) begin
         s_en_q[cfg_idx]  <= cfg_en;
         s_src_q[cfg_idx] <= cfg_src;
         s_dir_q[cfg_idx] <= cfg_dir;
         s_dst_q[cfg_idx] <= cfg_dst;
         s_rem_q[cfg_idx] <= cfg_remote;
         s_rv_q[cfg_idx]  <= cfg_rvlan;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg_ack_q      <= 1'b0;
         cfg_err_q      <= spm_pkg::SPM_ERR_NONE;
         cnt_clr_q      <= 1'b0;
         cnt_clr_port_q <= '0;
      end else begin
         cfg_ack_q      <= cfg_we;
         cfg_err_q      <= err;
         cnt_clr_q      <= cfg_acc && cfg_en;
         cnt_clr_port_q <= cfg_dst;
      end
   end

   for (genvar p = 0; p < NPORT; p++) begin : g_mtu
      always_ff @(posedge clk_sys) begin
         if (srst) port_mtu_q[p*14 +: 14] <= `SPM_MTU_DEFAULT;
         else port_mtu_q[p*14 +: 14] <= dst_used[p] ? `SPM_MTU_JUMBO
                                                     : `SPM_MTU_DEFAULT;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   AST_PAUSE_NO_COPY: assert property (
      pkt_valid && pkt_pause && !mir_valid_q |=> !mir_valid_q)
      else $error("pause frame was mirrored");
   AST_FWD_KEEP: assert property (
      pkt_valid && !unk_untag |=> fwd_valid_q && fwd_id_q == $past(pkt_id))
      else $error("original packet altered or lost");
   AST_UNTAG_DROP: assert property (
      pkt_valid && unk_untag |=> !fwd_valid_q ##0 $stable(mir_id_q))
      else $error("unknown-mode untagged packet passed");
   AST_STALL_DROP: assert property (
      stall && cand |=> mir_drop_q && $stable(mir_id_q) && mir_valid_q)
      else $error("stalled copy not dropped");
   AST_LEARN_OFF: assert property (
      pkt_valid && pkt_learn && rv_hit_pkt |=> !learn_valid_q)
      else $error("learning in remote mirror vlan");
   AST_REMOTE_VLAN: assert property (
      copy_go && s_rem_q[sel] |=> mir_valid_q && mir_tagged_q &&
                                  mir_vlan_q == $past(s_rv_q[sel]))
      else $error("remote copy lacks remote vlan");
   AST_CNT_CLR: assert property (
      cfg_acc && cfg_en |=> cnt_clr_q && cnt_clr_port_q == $past(cfg_dst))
      else $error("counters not cleared on designation");
   AST_TRILL_DST: assert property (
      cfg_we && cfg_en && port_trill[cfg_dst] |=>
         cfg_ack_q && cfg_err_q != spm_pkg::SPM_ERR_NONE)
      else $error("trill destination accepted");
   AST_BIDIR_EXCL: assert property (
      cfg_we && cfg_en && bidir_hit |=>
         cfg_err_q != spm_pkg::SPM_ERR_NONE && !cnt_clr_q)
      else $error("bidirectional exclusivity broken");
   AST_REMOTE_UNTAG: assert property (
      pkt_valid && hit_any && rem_untag |=> $stable(mir_id_q) && !mir_drop_q)
      else $error("untagged remote copy from non layer 2 source passed");
   AST_ISL_REMOTE: assert property (
      cfg_we && cfg_en && cfg_remote && port_isl[cfg_src] |=>
         cfg_ack_q && cfg_err_q != spm_pkg::SPM_ERR_NONE)
      else $error("inter-switch link source accepted for remote");

   COV_REMOTE_COPY: cover property (copy_go && s_rem_q[sel] ##1 mir_ready);
   COV_STALL_DROP:  cover property (stall && cand);
   COV_CFG_ACCEPT:  cover property (cfg_acc && cfg_en ##1 cnt_clr_q);
   COV_REMOTE_UNTAG: cover property (pkt_valid && hit_any && rem_untag);
endmodule

// ==== spm_analyzer.sv ====
// Traffic analyzer model sitting on the mirror destination port.
// Assumes the core holds each copy until mir_ready is sampled high.
`timescale 1ns/1ps
module spm_analyzer (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        mir_valid_q,
   input  wire logic        stall,
   output logic             mir_ready,
   output logic [15:0]      rx_count
);
   // Ready lags stall by one edge, as a port backing off would
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mir_ready <= 1'b0;
      end else begin
         mir_ready <= !stall;
      end
   end

   // Copies taken off the port, one per edge with valid and ready
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rx_count <= 16'h0000;
      end else if (mir_valid_q && mir_ready) begin
         rx_count <= rx_count + 16'h0001;
      end
   end
endmodule

// ==== switch_port_mirroring_test.sv ====
// Self-checking bench for the port mirroring core against a queue-free model.
// Assumes spm_pkg and spm_analyzer are compiled before this file.
`timescale 1ns/1ps
`include "spm_consts.svh"
module switch_port_mirroring_test;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic cfg_we = 1'b0, cfg_en = 1'b0, cfg_remote = 1'b0, rv_req = 1'b0;
   logic rv_add = 1'b1, rv_native = 1'b0, rv_members = 1'b0, stall = 1'b0;
   logic [5:0] cfg_idx = 6'h00, cfg_src = 6'h00, cfg_dst = 6'h00;
   logic [5:0] pkt_port = 6'h00, dst_rate_gbps = 6'h28;
   logic [11:0] cfg_rvlan = 12'h000, rv_vlan = 12'h000, pkt_vlan = 12'h000;
   spm_pkg::spm_dir_t cfg_dir = spm_pkg::SPM_DIR_OFF;
   // Port 4 unknown mode, 5 layer 3 only, 6 inter-switch link,
   // 7 an aggregate, 8 TRILL
   logic [63:0] port_lag = 64'h0000_0000_0000_0080;
   logic [63:0] port_trill = 64'h0000_0000_0000_0100;
   logic [63:0] port_isl = 64'h0000_0000_0000_0040;
   logic [63:0] port_l2 = 64'hFFFF_FFFF_FFFF_FFCF;
   logic [63:0] port_l3 = 64'h0000_0000_0000_0020;
   logic [63:0] port_mtu_dflt = 64'hFFFF_FFFF_FFFF_FDFF;
   logic pkt_valid = 1'b0, pkt_dir = 1'b0, pkt_tagged = 1'b0;
   logic pkt_pause = 1'b0, pkt_mcast = 1'b0, pkt_bcast = 1'b0, pkt_learn = 1'b1;
   logic [15:0] pkt_id = 16'h0000;
   logic [13:0] pkt_len = 14'h0040;
   logic cfg_ack_q, rv_ack_q, rv_ok_q, fwd_valid_q, learn_valid_q;
   logic mir_valid_q, mir_ready, mir_tagged_q, mir_remote_q, mir_drop_q;
   logic stat_tx_mc_q, stat_tx_bc_q, cnt_clr_q;
   spm_pkg::spm_err_t cfg_err_q;
   logic [15:0] fwd_id_q, learn_id_q, mir_id_q, held;
   logic [5:0] mir_port_q, cnt_clr_port_q;
   logic [11:0] mir_vlan_q;
   logic [13:0] mir_len_q;
   logic [895:0] port_mtu_q;
   logic [15:0] rx_count;
   int failures = 0, check_count = 0, copies = 0;
   int s_src[4], s_dir[4], s_dst[4], s_rem[4], s_rv[4];
   bit s_en[4];
   int ports[3] = '{1, 3, 4};

   // Small bucket so the bench can refill it in under a hundred cycles
   spm_mirror #(.BURST_BITS(16384)) dut_u (.*);
   spm_analyzer ana_u (.clk_sys(clk_sys), .srst(srst), .stall(stall),
                       .mir_valid_q(mir_valid_q), .mir_ready(mir_ready),
                       .rx_count(rx_count));

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic complete_run;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Lowest matching session wins, as the core picks one copy only
   function automatic int hit(int p, bit d, bit t, bit pz);
      if (pz || (!t && p == 4)) return -1;
      for (int i = 0; i < 4; i++) begin
         if (s_en[i] && s_src[i] == p && s_dir[i][d])
            return (s_rem[i] && !t && p == 5) ? -1 : i;
      end
      return -1;
   endfunction

   task automatic rvr(input bit nat, mem, input logic [11:0] v, input bit ok);
      @(posedge clk_sys);
      rv_req <= 1'b1;
      rv_vlan <= v;
      rv_native <= nat;
      rv_members <= mem;
      @(posedge clk_sys);
      rv_req <= 1'b0;
      #1;
      check("rv_ack", rv_ack_q, 1);
      check("rv_ok", rv_ok_q, ok);
   endtask

   task automatic cfg(input int i, input bit en, input int s,
                      input spm_pkg::spm_dir_t d, input int ds, input bit r,
                      input int rv, input spm_pkg::spm_err_t e);
      @(posedge clk_sys);
      cfg_we <= 1'b1;
      cfg_idx <= 6'(i);
      cfg_en <= en;
      cfg_src <= 6'(s);
      cfg_dir <= d;
      cfg_dst <= 6'(ds);
      cfg_remote <= r;
      cfg_rvlan <= 12'(rv);
      @(posedge clk_sys);
      cfg_we <= 1'b0;
      #1;
      check("ack", cfg_ack_q, 1);
      check("err", cfg_err_q, e);
      if (e != spm_pkg::SPM_ERR_NONE) return;
      check("clr", cnt_clr_q, en);
      if (en) check("clr_port", cnt_clr_port_q, ds);
      s_en[i] = en;
      s_src[i] = s;
      s_dir[i] = d;
      s_dst[i] = ds;
      s_rem[i] = r;
      s_rv[i] = rv;
      if (!en) return;
      @(posedge clk_sys);
      #1;
      check("mtu", port_mtu_q[ds*14+:14], `SPM_MTU_JUMBO);
   endtask

   task automatic pkt(input int p, input bit d, t, pz, mc,
                      input logic [11:0] v);
      int h;
      bit busy;
      logic [15:0] id;
      logic [13:0] len;
      h = hit(p, d, t, pz);
      id = 16'($urandom);
      len = 14'(64 + $urandom_range(63));
      busy = stall && mir_valid_q === 1'b1;
      @(posedge clk_sys);
      pkt_valid <= 1'b1;
      pkt_id <= id;
      pkt_port <= 6'(p);
      pkt_dir <= d;
      pkt_tagged <= t;
      pkt_vlan <= v;
      pkt_pause <= pz;
      pkt_mcast <= mc;
      pkt_bcast <= !mc;
      pkt_len <= len;
      @(posedge clk_sys);
      pkt_valid <= 1'b0;
      #1;
      check("fwd", fwd_valid_q, !(p == 4 && !t));
      if (p != 4 || t) check("fwd_id", fwd_id_q, id);
      check("learn_id", learn_id_q, id);
      check("learn", learn_valid_q, v != 12'h064 && !(p == 4 && !t));
      check("drop", mir_drop_q, busy && h >= 0);
      if (busy) return;
      check("copy", mir_valid_q, h >= 0);
      if (h < 0) return;
      copies++;
      check("id", mir_id_q, id);
      check("len", mir_len_q, len);
      check("port", mir_port_q, s_dst[h]);
      check("vlan", mir_vlan_q, s_rem[h] ? s_rv[h] : v);
      check("tag", mir_tagged_q, s_rem[h] ? 1 : t);
      check("remote", mir_remote_q, s_rem[h]);
      @(posedge clk_sys);
      #1;
      check("mc", stat_tx_mc_q, mc && !stall);
      check("bc", stat_tx_bc_q, !mc && !stall);
   endtask

   initial begin
      void'($urandom(89608));
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (100) @(posedge clk_sys);
      check("mtu0", port_mtu_q[2*14+:14], `SPM_MTU_DEFAULT);
      rvr(0, 0, 12'h064, 1);
      rvr(1, 0, 12'h0C8, 0);
      rvr(0, 1, 12'h0C9, 0);
      cfg(0, 1, 1, spm_pkg::SPM_DIR_RX, 2, 0, 0, spm_pkg::SPM_ERR_NONE);
      cfg(1, 1, 3, spm_pkg::SPM_DIR_BOTH, 20, 1, 100, spm_pkg::SPM_ERR_NONE);
      cfg(2, 1, 4, spm_pkg::SPM_DIR_RX, 2, 0, 0, spm_pkg::SPM_ERR_NONE);
      cfg(3, 1, 7, spm_pkg::SPM_DIR_RX, 5, 0, 0, spm_pkg::SPM_ERR_LAG);
      cfg(3, 1, 1, spm_pkg::SPM_DIR_RX, 8, 0, 0, spm_pkg::SPM_ERR_TRILL_DST);
      cfg(3, 1, 1, spm_pkg::SPM_DIR_RX, 5, 1, 200, spm_pkg::SPM_ERR_RVLAN);
      cfg(3, 1, 1, spm_pkg::SPM_DIR_TX, 18, 0, 0, spm_pkg::SPM_ERR_BIDIR);
      cfg(3, 1, 6, spm_pkg::SPM_DIR_RX, 5, 1, 100,
          spm_pkg::SPM_ERR_ISL_REMOTE);
      cfg(3, 1, 1, spm_pkg::SPM_DIR_RX, 9, 0, 0, spm_pkg::SPM_ERR_MTU);
      cfg(3, 1, 5, spm_pkg::SPM_DIR_RX, 20, 1, 100, spm_pkg::SPM_ERR_NONE);
      pkt(1, 0, 1, 0, 1, 12'h005);
      pkt(1, 1, 1, 0, 0, 12'h005);
      pkt(1, 0, 1, 1, 0, 12'h005);
      pkt(3, 1, 0, 0, 1, 12'h007);
      pkt(3, 0, 1, 0, 0, 12'h064);
      pkt(4, 0, 0, 0, 0, 12'h009);
      pkt(5, 0, 0, 0, 0, 12'h00A);
      pkt(5, 0, 1, 0, 1, 12'h00B);
      for (int n = 0; n < 16; n++) begin
         pkt(ports[$urandom_range(2)], 1'($urandom), 1'($urandom),
             $urandom_range(7) == 0, 1'($urandom),
             12'(1 + $urandom_range(98)));
      end
      // Held copy must survive a second copy arriving under stall
      @(posedge clk_sys);
      stall <= 1'b1;
      repeat (2) @(posedge clk_sys);
      pkt(1, 0, 1, 0, 0, 12'h011);
      held = mir_id_q;
      pkt(1, 0, 1, 0, 0, 12'h012);
      check("held", mir_id_q, held);
      @(posedge clk_sys);
      stall <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("idle", mir_valid_q, 0);
      cfg(2, 0, 4, spm_pkg::SPM_DIR_RX, 2, 0, 0, spm_pkg::SPM_ERR_NONE);
      cfg(0, 0, 1, spm_pkg::SPM_DIR_RX, 2, 0, 0, spm_pkg::SPM_ERR_NONE);
      @(posedge clk_sys);
      #1;
      check("mtu_back", port_mtu_q[2*14+:14], `SPM_MTU_DEFAULT);
      check("rx_count", rx_count, copies);
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      complete_run();
   end
endmodule
